// ### verilog/ntsc_timer_ctrl.sv
// Timer, mask, no-response and squelch control with AXI4-Lite registers
`timescale 1ns/100ps
`include "ntsc_defs.svh"
module ntsc_timer_ctrl
  import ntsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Framing events and carrier time base, one-cycle pulses
  input wire logic carrier_tick,
  input wire logic rx_start,
  input wire logic rx_end,
  input wire logic tx_end,
  // Settings held elsewhere in the register bank
  input wire logic [7:0] mask_time,
  input wire logic [15:0] noresp_time,
  // Receiver gain reduction level
  input wire logic [7:0] gain_level,
  // Timer results
  output logic gpt_expired,
  output logic noresp_expired,
  output logic rx_masked,
  output logic squelch_on,
  output logic gain_lock,
  output logic [7:0] agc_start_gain
);
  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  logic [7:0] sqt_r;
  logic [7:0] ctrl_r;
  logic [7:0] gpt_hi_r;
  logic [7:0] gpt_lo_r;
  logic [7:0] agc_r;
  logic gpt_cmd_r;

  logic aw_held_r;
  logic [7:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic wr_go;
  logic [5:0] wr_idx;
  logic wr_ok;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_ok;

  logic [2:0] trig_sel;
  logic hw_trig;
  logic sq_own;
  logic sq_own_r;
  ntsc_sq_state_type sq_state_r;
  logic [8:0] dly_r;
  logic sq_end;
  logic [7:0] status;

  ntsc_cnt_if gpt_if ();
  ntsc_cnt_if mrt_if ();
  ntsc_cnt_if sqt_if ();
  ntsc_cnt_if nrt_if ();

  //--------------------------------------------------------------------
  // AXI4-Lite write channel
  //--------------------------------------------------------------------
  // Address and data are taken in either order, held until both arrive
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx = awaddr_r[7:2];

  // Decode of writable and readable indices
  always_comb
  begin
    case (wr_idx)
      `NTSC_IDX_SQT, `NTSC_IDX_CTRL, `NTSC_IDX_GPT_HI, `NTSC_IDX_GPT_LO,
      `NTSC_IDX_RSVD, `NTSC_IDX_STATUS, `NTSC_IDX_CMD, `NTSC_IDX_AGC:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // Address holding
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;
  end

  // Data holding
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_r <= 1'b0;
  end

  // Response; unmapped addresses answer with a decode error
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `NTSC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? `NTSC_RESP_OKAY : `NTSC_RESP_DECERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Register file; only byte lane 0 carries data
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sqt_r <= `NTSC_RST_SQT;
      ctrl_r <= `NTSC_RST_CTRL;
      gpt_hi_r <= `NTSC_RST_GPT;
      gpt_lo_r <= `NTSC_RST_GPT;
    end
    else if (wr_go && wstrb_r[0])
    begin
      case (wr_idx)
        `NTSC_IDX_SQT: sqt_r <= wdata_r[7:0];
        `NTSC_IDX_CTRL: ctrl_r <= wdata_r[7:0] & `NTSC_CTRL_MASK;
        `NTSC_IDX_GPT_HI: gpt_hi_r <= wdata_r[7:0];
        `NTSC_IDX_GPT_LO: gpt_lo_r <= wdata_r[7:0];
        default: ;
      endcase
    end
  end

  // Start command is a pulse, the register itself holds nothing
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      gpt_cmd_r <= 1'b0;
    else
      gpt_cmd_r <= wr_go && wstrb_r[0] && (wr_idx == `NTSC_IDX_CMD) &&
        wdata_r[`NTSC_CMD_GPT_BIT];
  end

  //--------------------------------------------------------------------
  // AXI4-Lite read channel
  //--------------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_idx = s_axi_araddr[7:2];
  assign status = {4'h0, nrt_if.busy, squelch_on, rx_masked, gpt_if.busy};

  // Read mux; reserved and write-only slots read zero
  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case (rd_idx)
      `NTSC_IDX_SQT: rd_byte = sqt_r;
      `NTSC_IDX_CTRL: rd_byte = ctrl_r;
      `NTSC_IDX_GPT_HI: rd_byte = gpt_hi_r;
      `NTSC_IDX_GPT_LO: rd_byte = gpt_lo_r;
      `NTSC_IDX_RSVD: rd_byte = 8'h00;
      `NTSC_IDX_STATUS: rd_byte = status;
      `NTSC_IDX_CMD: rd_byte = 8'h00;
      `NTSC_IDX_AGC: rd_byte = agc_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read data registered, held until taken
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `NTSC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_ok ? `NTSC_RESP_OKAY : `NTSC_RESP_DECERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  //--------------------------------------------------------------------
  // General purpose timer
  //--------------------------------------------------------------------
  assign trig_sel = ctrl_r[`NTSC_TRIG_HI:`NTSC_TRIG_LO];

  // Hardware trigger by source select; reserved codes add nothing
  always_comb
  begin
    case (trig_sel)
      `NTSC_TRIG_NONE: hw_trig = 1'b0;
      `NTSC_TRIG_RXE: hw_trig = rx_end;
      `NTSC_TRIG_RXS: hw_trig = rx_start;
      `NTSC_TRIG_TXE: hw_trig = tx_end;
      default: hw_trig = 1'b0;
    endcase
  end

  assign gpt_if.start = gpt_cmd_r || hw_trig;
  assign gpt_if.stop = 1'b0;
  assign gpt_if.load = {gpt_hi_r, gpt_lo_r};
  assign gpt_if.div = `NTSC_DIV_GPT;
  assign gpt_if.tick = carrier_tick;
  assign gpt_expired = gpt_if.done;

  ntsc_stepcnt u_gpt (.mclk(mclk), .nrst(nrst), .c(gpt_if));

  //--------------------------------------------------------------------
  // Mask receive timer
  //--------------------------------------------------------------------
  assign mrt_if.start = tx_end;
  assign mrt_if.stop = 1'b0;
  assign mrt_if.load = {8'h00, mask_time};
  assign mrt_if.div = ctrl_r[`NTSC_MRT_STEP_BIT] ?
    `NTSC_DIV_512 : `NTSC_DIV_64;
  assign mrt_if.tick = carrier_tick;
  assign rx_masked = mrt_if.busy;

  ntsc_stepcnt u_mrt (.mclk(mclk), .nrst(nrst), .c(mrt_if));

  //--------------------------------------------------------------------
  // No-response timer
  //--------------------------------------------------------------------
  // Compliance mode keeps counting through a reception
  assign nrt_if.start = tx_end;
  assign nrt_if.stop = rx_start && !tx_end &&
    !ctrl_r[`NTSC_NRT_COMPLY_BIT];
  assign nrt_if.load = noresp_time;
  assign nrt_if.div = ctrl_r[`NTSC_NRT_STEP_BIT] ?
    `NTSC_DIV_4096 : `NTSC_DIV_64;
  assign nrt_if.tick = carrier_tick;
  assign noresp_expired = nrt_if.done;

  ntsc_stepcnt u_nrt (.mclk(mclk), .nrst(nrst), .c(nrt_if));

  //--------------------------------------------------------------------
  // Squelch
  //--------------------------------------------------------------------
  // Own duration only when above the floor and shorter than the mask
  assign sq_own = (sqt_r > `NTSC_SQT_MIN) && (sqt_r < mask_time);
  assign sqt_if.start = tx_end && sq_own;
  assign sqt_if.stop = 1'b0;
  assign sqt_if.load = {8'h00, sqt_r};
  assign sqt_if.div = mrt_if.div;
  assign sqt_if.tick = carrier_tick;

  ntsc_stepcnt u_sqt (.mclk(mclk), .nrst(nrst), .c(sqt_if));

  // Squelch ends when the chosen counter stops running
  assign sq_end = sq_own_r ? !sqt_if.busy : !mrt_if.busy;
  assign squelch_on = (sq_state_r == SQ_ON);

  // Squelch sequence; a new end of transmission always restarts it
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sq_state_r <= SQ_IDLE;
      sq_own_r <= 1'b0;
      dly_r <= 9'h000;
    end
    else if (tx_end)
    begin
      sq_state_r <= SQ_WAIT;
      sq_own_r <= sq_own;
      dly_r <= 9'h000;
    end
    else
    begin
      case (sq_state_r)
        SQ_IDLE: ;
        SQ_WAIT:
        begin
          dly_r <= dly_r + 9'h001;
          if (dly_r == 9'(`NTSC_SQ_DLY_CYC - 1))
            sq_state_r <= sq_end ? SQ_IDLE : SQ_ON;
        end
        SQ_ON:
          if (sq_end)
            sq_state_r <= SQ_IDLE;
        default:
          sq_state_r <= SQ_IDLE;
      endcase
    end
  end

  // Gain frozen at an own-timer end becomes the AGC starting point
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      gain_lock <= 1'b0;
      agc_r <= 8'h00;
    end
    else
    begin
      gain_lock <= squelch_on && sq_own_r && sq_end && !tx_end;
      if (squelch_on && sq_own_r && sq_end && !tx_end)
        agc_r <= gain_level;
    end
  end

  assign agc_start_gain = agc_r;
endmodule

// ### verilog/ntsc_defs.svh
// Constants of the timer and squelch control block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef NTSC_DEFS_SVH
`define NTSC_DEFS_SVH

// Register indices, byte address is four times the index
`define NTSC_IDX_SQT 6'h0F
`define NTSC_IDX_CTRL 6'h12
`define NTSC_IDX_GPT_HI 6'h13
`define NTSC_IDX_GPT_LO 6'h14
`define NTSC_IDX_RSVD 6'h15
`define NTSC_IDX_STATUS 6'h20
`define NTSC_IDX_CMD 6'h21
`define NTSC_IDX_AGC 6'h22

// Reset values
`define NTSC_RST_SQT 8'h00
`define NTSC_RST_CTRL 8'h00
`define NTSC_RST_GPT 8'h00

// Control field positions
`define NTSC_TRIG_HI 7
`define NTSC_TRIG_LO 5
`define NTSC_MRT_STEP_BIT 3
`define NTSC_NRT_COMPLY_BIT 1
`define NTSC_NRT_STEP_BIT 0
`define NTSC_CMD_GPT_BIT 0
`define NTSC_CTRL_MASK 8'hEB

// Trigger codes
`define NTSC_TRIG_NONE 3'h0
`define NTSC_TRIG_RXE 3'h1
`define NTSC_TRIG_RXS 3'h2
`define NTSC_TRIG_TXE 3'h3

// Step sizes in carrier periods
`define NTSC_DIV_GPT 13'h0008
`define NTSC_DIV_64 13'h0040
`define NTSC_DIV_512 13'h0200
`define NTSC_DIV_4096 13'h1000

// Squelch own-timer threshold
`define NTSC_SQT_MIN 8'h05

// Squelch delay after end of transmission
`define NTSC_SQ_DLY_NS 20000
`define NTSC_CLK_NS 50
`define NTSC_SQ_DLY_CYC ((`NTSC_SQ_DLY_NS + `NTSC_CLK_NS - 1) / `NTSC_CLK_NS)

// Bus answers
`define NTSC_RESP_OKAY 2'h0
`define NTSC_RESP_DECERR 2'h3

`endif

// ### verilog/ntsc_pkg.sv
// Types of the timer and squelch control block
package ntsc_pkg;
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_ON} ntsc_sq_state_type;
endpackage

// ### verilog/ntsc_cnt_if.sv
// Interface between the control logic and one step counter
`timescale 1ns/100ps
interface ntsc_cnt_if;
  logic start;
  logic stop;
  logic [15:0] load;
  logic [12:0] div;
  logic tick;
  logic busy;
  logic done;
  modport ctl (output start, stop, load, div, tick, input busy, done);
  modport cnt (input start, stop, load, div, tick, output busy, done);
endinterface

// ### verilog/ntsc_stepcnt.sv
// Down counter of steps, each step a number of carrier ticks
`timescale 1ns/100ps
module ntsc_stepcnt
  import ntsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control side
  ntsc_cnt_if.cnt c
);
  logic [15:0] cnt_r;
  logic [12:0] pre_r;
  logic busy_r;
  logic done_r;
  logic step;

  // A step ends on the last carrier tick of the prescaler
  assign step = busy_r && c.tick && (pre_r == c.div - 13'h0001);
  assign c.busy = busy_r;
  assign c.done = done_r;

  // Step count; start reloads even while running
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
    end
    else if (c.stop)
      busy_r <= 1'b0;
    else if (c.start)
    begin
      busy_r <= (c.load != 16'h0000);
      cnt_r <= c.load;
    end
    else if (step)
    begin
      if (cnt_r == 16'h0001)
        busy_r <= 1'b0;
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // Prescaler restarts with the count so the first step is whole
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pre_r <= 13'h0000;
    else if (c.start)
      pre_r <= 13'h0000;
    else if (busy_r && c.tick)
      pre_r <= step ? 13'h0000 : pre_r + 13'h0001;
  end

  // One-cycle expiry pulse
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      done_r <= 1'b0;
    else
      done_r <= step && (cnt_r == 16'h0001) && !c.start && !c.stop;
  end
endmodule

// ### dv/ntsc_timer_ctrl_chk.sv
// Checker of the timer and squelch control block ports
`timescale 1ns/100ps
`include "ntsc_defs.svh"
module ntsc_timer_ctrl_chk
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events and results
  input wire logic tx_end,
  input wire logic [7:0] mask_time,
  input wire logic gpt_expired,
  input wire logic rx_masked,
  input wire logic squelch_on,
  input wire logic gain_lock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [5:0] ar_idx_r;
  // Index of the read in flight, to judge its data
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ar_idx_r <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ar_idx_r <= s_axi_araddr[7:2];
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rsvd;
    s_axi_rvalid && ar_idx_r == `NTSC_IDX_RSVD |-> s_axi_rdata == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_gpt;
    gpt_expired |=> !gpt_expired;
  endproperty
  a_gpt: assert property (p_gpt) else $error("expiry not a pulse");
  property p_mask;
    tx_end && mask_time != 8'h00 |=> rx_masked [*8];
  endproperty
  a_mask: assert property (p_mask) else $error("mask not started");
  property p_sqdly;
    tx_end |=> !squelch_on [*8];
  endproperty
  a_sqdly: assert property (p_sqdly) else $error("squelch too early");
  property p_sqmask;
    $fell(rx_masked) |-> ##[0:2] !squelch_on;
  endproperty
  a_sqmask: assert property (p_sqmask) else $error("squelch past mask");
  property p_lock;
    gain_lock |-> !squelch_on ##1 !gain_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("lock pulse wrong");
  // Main scenarios reached
  c_lock: cover property (gain_lock);
  c_gpt: cover property (gpt_expired);
  c_sq: cover property ($rose(squelch_on));
endmodule

bind ntsc_timer_ctrl ntsc_timer_ctrl_chk i_chk (.mclk(mclk), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_end(tx_end), .mask_time(mask_time),
  .gpt_expired(gpt_expired), .rx_masked(rx_masked),
  .squelch_on(squelch_on), .gain_lock(gain_lock));

// ### dv/tb_top.sv
// Self-checking bench of the timer and squelch control block
`timescale 1ns/100ps
`include "ntsc_defs.svh"
module tb_top;
  logic mclk = 0, nrst = 0, tick = 0, m_q = 0, s_q = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, mask_time = 0, gain_level = 0, v;
  logic [31:0] wdata = 0, rdata;
  logic [15:0] noresp_time = 0;
  logic [2:0] evs = 0;
  logic awready, wready, bvalid, arready, rvalid, gpt_expired;
  logic noresp_expired, rx_masked, squelch_on, gain_lock;
  logic [1:0] bresp, rresp;
  logic [7:0] agc_start_gain;
  logic [5:0] ri [5] = '{`NTSC_IDX_SQT, `NTSC_IDX_CTRL, `NTSC_IDX_GPT_HI,
    `NTSC_IDX_GPT_LO, `NTSC_IDX_RSVD};
  int failures = 0, check_count = 0, cyc = 0, seed = 32'h0d7c;
  int n_gpt = 0, t_gpt = 0, n_nr = 0, t_nr = 0, n_lock = 0, t0 = 0;
  int t_mr = 0, t_mf = 0, t_sr = 0, t_sf = 0, n, k, own;
  ntsc_timer_ctrl i_dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .carrier_tick(tick), .rx_start(evs[1]),
    .rx_end(evs[0]), .tx_end(evs[2]), .mask_time(mask_time),
    .noresp_time(noresp_time), .gain_level(gain_level),
    .gpt_expired(gpt_expired), .noresp_expired(noresp_expired),
    .rx_masked(rx_masked), .squelch_on(squelch_on), .gain_lock(gain_lock),
    .agc_start_gain(agc_start_gain));
  // 20 MHz clock
  always #25 mclk = ~mclk;
  // Event log of the results, times in clock cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (gpt_expired === 1'b1)
    begin
      n_gpt <= n_gpt + 1;
      t_gpt <= cyc;
    end
    if (noresp_expired === 1'b1)
    begin
      n_nr <= n_nr + 1;
      t_nr <= cyc;
    end
    if (gain_lock === 1'b1)
      n_lock <= n_lock + 1;
    if (rx_masked !== m_q)
      if (m_q) t_mf <= cyc; else t_mr <= cyc;
    if (squelch_on !== s_q)
      if (s_q) t_sf <= cyc; else t_sr <= cyc;
    m_q <= rx_masked === 1'b1;
    s_q <= squelch_on === 1'b1;
  end
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task end_sim;
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Time window check; edges of the bus leave a few cycles of slack
  task rng(input string nm, input int e, input int g);
    check_count++;
    if (g < e - 4 || g > e + 4)
    begin
      failures++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // Ready is sampled at the falling edge, so the rising edge never races;
  // response ready lags valid by one cycle so the hold rules are exercised
  task axi_wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b, dn;
    logic [1:0] r;
    @(posedge mclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    n = 0;
    dn = 0;
    while (!dn)
    begin
      @(negedge mclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid === 1'b1;
      dn = b && bready;
      r = bresp;
      @(posedge mclk);
      if (a) awvalid <= 0;
      if (w) wvalid <= 0;
      if (dn) bready <= 0;
      else if (b) bready <= 1;
      n++;
      if (n > 100)
      begin
        failures++;
        end_sim;
      end
    end
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task axi_rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
    logic a, rv, dn;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    araddr <= {i, 2'h0};
    arvalid <= 1;
    n = 0;
    dn = 0;
    while (!dn)
    begin
      @(negedge mclk);
      a = arvalid && arready;
      rv = rvalid === 1'b1;
      dn = rv && rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (a) arvalid <= 0;
      if (dn) rready <= 0;
      else if (rv) rready <= 1;
      n++;
      if (n > 100)
      begin
        failures++;
        end_sim;
      end
    end
    cmp("rdata", {24'h0, e}, d);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task run(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // One-cycle framing event: 0 end of rx, 1 start of rx, 2 end of tx
  task ev(input int e);
    @(posedge mclk);
    evs <= 3'h1 << e;
    t0 = cyc;
    @(posedge mclk);
    evs <= 3'h0;
  endtask
  task go;
    axi_wr(`NTSC_IDX_CMD, 8'h01, `NTSC_RESP_OKAY);
    t0 = cyc;
  endtask
  task nr_case(input logic [7:0] c, input int rx, input int e);
    axi_wr(`NTSC_IDX_CTRL, c, `NTSC_RESP_OKAY);
    k = n_nr;
    ev(2);
    if (rx)
    begin
      run(50);
      ev(1);
    end
    run(250);
    cmp("noresp count", k + e, n_nr);
  endtask
  // ----------------------------------------
  // Main sequence, carrier tick every cycle
  // ----------------------------------------
  initial
  begin
    run(5);
    nrst <= 1;
    tick <= 1;
    for (int i = 0; i < 5; i++)
      axi_rd(ri[i], 8'h00, `NTSC_RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      v = 8'($random(seed));
      axi_wr(ri[i], v, `NTSC_RESP_OKAY);
      axi_rd(ri[i], i == 4 ? 8'h00 : i == 1 ? v & `NTSC_CTRL_MASK : v,
        `NTSC_RESP_OKAY);
    end
    axi_wr(6'h30, 8'hFF, `NTSC_RESP_DECERR);
    axi_rd(6'h30, 8'h00, `NTSC_RESP_DECERR);
    n = 1 + ($random(seed) & 15);
    k = n;
    axi_wr(`NTSC_IDX_CTRL, 8'h00, `NTSC_RESP_OKAY);
    axi_wr(`NTSC_IDX_GPT_HI, 8'h01, `NTSC_RESP_OKAY);
    axi_wr(`NTSC_IDX_GPT_LO, k[7:0], `NTSC_RESP_OKAY);
    go;
    run(2058 + k * 8);
    cmp("gpt count", 1, n_gpt);
    rng("gpt time", (256 + k) * 8, t_gpt - t0);
    axi_wr(`NTSC_IDX_GPT_HI, 8'h00, `NTSC_RESP_OKAY);
    go;
    run(k * 2);
    go;
    run(k * 8 + 10);
    cmp("gpt restart", 2, n_gpt);
    rng("gpt restart time", k * 8, t_gpt - t0);
    for (int c = 0; c < 8; c++)
    begin
      axi_wr(`NTSC_IDX_CTRL, 8'(c << 5), `NTSC_RESP_OKAY);
      for (int e = 0; e < 3; e++)
      begin
        n = n_gpt;
        own = c == e + 1;
        ev(e);
        run(k * 8 + 10);
        cmp("trigger", n + own, n_gpt);
      end
    end
    axi_wr(`NTSC_IDX_CTRL, 8'h00, `NTSC_RESP_OKAY);
    mask_time <= 8'h14;
    gain_level <= 8'($random(seed));
    foreach (ri[s])
      if (s < 3)
      begin
        own = s == 0;
        axi_wr(`NTSC_IDX_SQT, s == 0 ? 8'h0A : s == 1 ? 8'h03 : 8'h19,
          `NTSC_RESP_OKAY);
        n = n_lock;
        ev(2);
        run(1400);
        rng("mask len", 1280, t_mf - t_mr);
        rng("squelch on", 400, t_sr - t0);
        rng("sq off", own ? 640 : 0, t_sf - (own ? t0 : t_mf));
        cmp("lock count", n + own, n_lock);
        if (own)
        begin
          cmp("agc gain", {24'h0, gain_level}, {24'h0, agc_start_gain});
          axi_rd(`NTSC_IDX_AGC, gain_level, `NTSC_RESP_OKAY);
        end
      end
    // Long mask step; own squelch must follow the same step
    axi_wr(`NTSC_IDX_CTRL, 8'h08, `NTSC_RESP_OKAY);
    axi_wr(`NTSC_IDX_SQT, 8'h06, `NTSC_RESP_OKAY);
    mask_time <= 8'h07;
    ev(2);
    run(3700);
    rng("mask len step", 3584, t_mf - t_mr);
    rng("squelch off step", 3072, t_sf - t0);
    mask_time <= 8'h00;
    noresp_time <= 16'h0003;
    nr_case(8'h00, 0, 1);
    rng("noresp time", 192, t_nr - t0);
    nr_case(8'h00, 1, 0);
    nr_case(8'h02, 1, 1);
    noresp_time <= 16'h0001;
    nr_case(8'h01, 0, 0);
    run(3900);
    rng("noresp step", 4096, t_nr - t0);
    end_sim;
  end
endmodule
